// ===== hw/gpio_interrupt_trigger_select.sv
// APB register block selecting per-pin interrupt trigger types
// Behaviour
// R1: Sense bit one selects level, zero edge
// R2: Reset clears sense, both-edges, polarity registers
// R3: Both-edges bit triggers on either edge
// R4: Both-edges zero: single edge by polarity
// R5: Polarity one: rising edge or high level
// R6: Polarity zero: falling edge or low level
// R7: Three registers hold eight read-write bits
// R8: Trigger sets raw status; mask gates interrupt
// R9: Synchronise pins, compare successive samples
`default_nettype none
module gpio_interrupt_trigger_select
  import trig_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Pins
  input  wire logic [7:0]  pin_in,
  // Interrupts
  output logic [7:0]       pin_irq,
  output logic             combined_port_interrupt
);
  logic [7:0]  sense_bits_reg;
  logic [7:0]  both_edges_bits_reg;
  logic [7:0]  polarity_bits_reg;
  logic [7:0]  pin_interrupt_mask_reg;
  logic [7:0]  raw_trigger_status_reg;
  logic [7:0]  pin_irq_reg;
  logic        irq_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [7:0]  trig;
  logic [7:0]  level;
  logic [7:0]  clear_bits;
  logic [7:0]  status_next;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      pin_trigger_detect u_det (
        .pclk         (pclk),
        .presetn      (presetn),
        .pin_async    (pin_in[g]),
        .sense_bit    (sense_bits_reg[g]),
        .both_bit     (both_edges_bits_reg[g]),
        .polarity_bit (polarity_bits_reg[g]),
        .pin_level    (level[g]),
        .trigger      (trig[g])
      );
    end
  endgenerate

  // Zero-wait APB: every access completes in its first access cycle
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign pin_irq = pin_irq_reg;
  assign combined_port_interrupt = irq_reg;

  always_comb begin
    case (paddr)
      OFS_SENSE, OFS_BOTH, OFS_POLARITY, OFS_MASK,
      OFS_RAW, OFS_MASKED, OFS_CLEAR, OFS_PIN_LEVEL: mapped = 1'b1;
      default:                                       mapped = 1'b0;
    endcase
  end

  // Configuration registers, low byte only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_bits_reg         <= CFG_RESET; // R2
      both_edges_bits_reg    <= CFG_RESET; // R2
      polarity_bits_reg      <= CFG_RESET; // R2
      pin_interrupt_mask_reg <= CFG_RESET;
    end else if (wr_acc) begin
      case (paddr)
        OFS_SENSE:    sense_bits_reg         <= pwdata[7:0]; // R7
        OFS_BOTH:     both_edges_bits_reg    <= pwdata[7:0]; // R7
        OFS_POLARITY: polarity_bits_reg      <= pwdata[7:0]; // R7
        OFS_MASK:     pin_interrupt_mask_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Raw status: write-one-to-clear, a new trigger wins over a clear
  assign clear_bits  = (wr_acc && paddr == OFS_CLEAR) ? pwdata[7:0] : 8'h00;
  assign status_next = (raw_trigger_status_reg & ~clear_bits) | trig; // R8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_trigger_status_reg <= 8'h00;
    end else begin
      raw_trigger_status_reg <= status_next; // R8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_irq_reg <= 8'h00;
      irq_reg     <= 1'b0;
    end else begin
      pin_irq_reg <= status_next & pin_interrupt_mask_reg; // R8
      irq_reg     <= |(status_next & pin_interrupt_mask_reg); // R8
    end
  end

  // Read data is captured in setup so it is valid during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= psel & ~penable & ~mapped;
      if (rd_acc) begin
        case (paddr)
          OFS_SENSE:     prdata_reg <= {RESERVED_READ[31:8], sense_bits_reg}; // R7
          OFS_BOTH:      prdata_reg <= {RESERVED_READ[31:8], both_edges_bits_reg}; // R7
          OFS_POLARITY:  prdata_reg <= {RESERVED_READ[31:8], polarity_bits_reg}; // R7
          OFS_MASK:      prdata_reg <= {RESERVED_READ[31:8], pin_interrupt_mask_reg};
          OFS_RAW:       prdata_reg <= {RESERVED_READ[31:8], raw_trigger_status_reg};
          OFS_MASKED:    prdata_reg <= {RESERVED_READ[31:8],
                                        raw_trigger_status_reg & pin_interrupt_mask_reg};
          OFS_PIN_LEVEL: prdata_reg <= {RESERVED_READ[31:8], level};
          default:       prdata_reg <= RESERVED_READ;
        endcase
      end else if (!psel) begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/pin_trigger_detect.sv
// Per-pin synchroniser and trigger detector
`default_nettype none
module pin_trigger_detect
  import trig_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and configuration
  input  wire logic pin_async,
  input  wire logic sense_bit,
  input  wire logic both_bit,
  input  wire logic polarity_bit,
  // Result
  output logic      pin_level,
  output logic      trigger
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise;
  logic fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_async; // R9
      sync2_reg <= sync1_reg; // R9
      prev_reg  <= sync2_reg; // R9
    end
  end

  assign pin_level = sync2_reg;
  assign rise      = sync2_reg & ~prev_reg; // R9
  assign fall      = ~sync2_reg & prev_reg; // R9

  always_comb begin
    if (sense_bit) begin
      trigger = polarity_bit ? sync2_reg : ~sync2_reg; // R1 R5 R6
    end else if (both_bit) begin
      trigger = rise | fall; // R3
    end else begin
      trigger = polarity_bit ? rise : fall; // R4 R5 R6
    end
  end
endmodule
`default_nettype wire

// ===== hw/trig_pkg.sv
// Constants for the pin trigger-select block
`default_nettype none
package trig_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam logic [11:0] OFS_SENSE     = 12'h404;
  localparam logic [11:0] OFS_BOTH      = 12'h408;
  localparam logic [11:0] OFS_POLARITY  = 12'h40C;
  localparam logic [11:0] OFS_MASK      = 12'h410;
  localparam logic [11:0] OFS_RAW       = 12'h414;
  localparam logic [11:0] OFS_MASKED    = 12'h418;
  localparam logic [11:0] OFS_CLEAR     = 12'h41C;
  localparam logic [11:0] OFS_PIN_LEVEL = 12'h420;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [31:0] RESERVED_READ = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== test/gpio_interrupt_trigger_select_tb.sv
// Bench for the trigger-select block
`default_nettype none
module gpio_interrupt_trigger_select_tb
  import trig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, combined_port_interrupt, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] lvl, pin_in, pin_irq;
  int bad_count, num_checks, cyc;
  gpio_interrupt_trigger_select i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in), .pin_irq(pin_irq),
    .combined_port_interrupt(combined_port_interrupt));
  pin_source i_pins (.level(lvl), .pin_in(pin_in));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, x, q);
  endtask
  // Raw status expected for sense F0, both 0C, polarity AA
  function automatic logic [7:0] want(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] s = 8'hF0, bb = 8'h0C, p = 8'hAA;
    for (int i = 0; i < 8; i++)
      want[i] = s[i] ? (a[i] == p[i] || b[i] == p[i]) : a[i] != b[i] && (bb[i] || b[i] == p[i]);
  endfunction
  task automatic trig_case(input logic [7:0] a, input logic [7:0] b);
    lvl <= a;
    repeat (4) @(posedge pclk);
    apb(1'b1, OFS_CLEAR, 32'h0000_00FF);
    lvl <= b;
    repeat (3) @(posedge pclk);
    rd(OFS_RAW, {24'h00_0000, want(a, b)}, "raw");
    chk("irq", {24'h00_0000, want(a, b) & 8'h55}, {24'h00_0000, pin_irq});
    chk("comb", {31'h0, |(want(a, b) & 8'h55)}, {31'h0, combined_port_interrupt});
  endtask
  task automatic reg_setup;
    rd(OFS_SENSE, 32'h0000_0000, "sense");
    rd(OFS_BOTH, 32'h0000_0000, "both");
    rd(OFS_POLARITY, 32'h0000_0000, "pol");
    apb(1'b1, OFS_POLARITY, 32'hFFFF_FFAA);
    rd(OFS_POLARITY, 32'h0000_00AA, "polw");
    apb(1'b1, OFS_SENSE, 32'h0000_00F0);
    apb(1'b1, OFS_BOTH, 32'h0000_000C);
    apb(1'b1, OFS_MASK, 32'h0000_0055);
  endtask
  task automatic bad_access;
    apb(1'b1, 12'h800, 32'h0000_0000);
    chk("err", 32'h0000_0001, {31'h0, e});
    apb(1'b1, OFS_MASK, 32'h0000_0000);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, lvl} = '0;
    {cyc, bad_count, num_checks} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reg_setup();
    trig_case(8'h00, 8'h0F);
    trig_case(8'h0F, 8'h00);
    trig_case(8'hF0, 8'h0F);
    bad_access();
    stop_test();
  end
endmodule
`default_nettype wire

// ===== test/pin_source.sv
// External pins feeding the port inputs
`default_nettype none
module pin_source (
  // Requested pin levels
  input  wire logic [7:0] level,
  // Pads
  output logic      [7:0] pin_in
);
  assign pin_in = level;
endmodule
`default_nettype wire

// ===== test/trig_sel_asserts.sv
// Port checker for the trigger-select block
`default_nettype none
module trig_sel_asserts
  import trig_pkg::*;
(
  // Clock, reset, bus, pins
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_irq,
  input wire logic        combined_port_interrupt
);
  logic wr_q;
  wire logic acc = psel && penable;
  wire logic bad = paddr < OFS_SENSE || paddr > OFS_PIN_LEVEL || paddr[1:0] != 2'b00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_q <= 1'b0;
    else wr_q <= acc && pwrite;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  comb_or_a: assert property (combined_port_interrupt == |pin_irq) else $error("or");
  mask_off_a: assert property (acc && pwrite && paddr == OFS_MASK && pwdata[7:0] == 8'h00
    |-> ##[1:2] pin_irq == 8'h00) else $error("mask");
  irq_fall_a: assert property ($fell(combined_port_interrupt) |-> wr_q || $past(wr_q))
    else $error("fall");
  rsvd_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("rsv");
  bad_addr_a: assert property (acc && bad |-> pslverr) else $error("err");
  good_addr_a: assert property (acc && !bad |-> !pslverr) else $error("ok");
  reset_out_a: assert property ($rose(presetn) |-> pin_irq == 8'h00) else $error("rst");
  ready_a: assert property (pready) else $error("rdy");
  cover property ($rose(combined_port_interrupt));
  cover property (acc && pslverr);
  cover property (acc && !pwrite && paddr == OFS_RAW);
endmodule
bind gpio_interrupt_trigger_select trig_sel_asserts i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in), .pin_irq(pin_irq),
  .combined_port_interrupt(combined_port_interrupt));
`default_nettype wire
